/* File: hw/tpcr_timer.sv */
// timer/counter with prescaler, 8/16-bit width and two compare registers
// assumes a cpu on an 8-bit i/o bus, single-cycle write/read strobes,
// and a cpu interrupt unit that pulses irq_ack when a vector runs
`timescale 1ns/1ns

module tpcr_timer
(
    input wire logic mclk, // 10 MHz system clock
    input wire logic sys_rst, // async reset, active high
    input wire logic [5:0] io_addr, // cpu i/o address
    input wire logic [7:0] io_wdata, // cpu write data
    input wire logic io_we, // write strobe, one cycle
    input wire logic io_re, // read strobe, one cycle
    output logic [7:0] io_rdata, // read data, valid cycle after io_re
    input wire logic external_count_pin, // external count source
    input wire logic global_irq_enable, // cpu global interrupt enable
    input wire logic capture_event, // capture trigger from front end
    input wire logic [3:0] irq_ack, // vector executed: cap, ovf, cmpb, cmpa
    output logic [3:0] irq_req // interrupt requests, same order
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] prescale_control;
    logic [7:0] width_control;
    logic [7:0] timer_irq_flags;
    logic [7:0] timer_irq_mask;
    logic [15:0] count;
    logic [7:0] compare_value_a;
    logic [7:0] compare_value_b;
    logic [7:0] temp_high;
    logic [tpcr_pkg::PSC_W-1:0] prescaler;
    logic ext_prev;
    logic match_block;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire wr_cnt_lo = io_we && (io_addr == tpcr_pkg::ADDR_CNT_LO);
    wire wr_cnt_hi = io_we && (io_addr == tpcr_pkg::ADDR_CNT_HI);
    wire wr_cmp_a = io_we && (io_addr == tpcr_pkg::ADDR_CMP_A);
    wire wr_cmp_b = io_we && (io_addr == tpcr_pkg::ADDR_CMP_B);
    wire wr_ctrl_a = io_we && (io_addr == tpcr_pkg::ADDR_CTRL_A);
    wire wr_psc = io_we && (io_addr == tpcr_pkg::ADDR_PSC_CTRL);
    wire wr_flags = io_we && (io_addr == tpcr_pkg::ADDR_FLAGS);
    wire wr_mask = io_we && (io_addr == tpcr_pkg::ADDR_MASK);
    wire rd_cnt_lo = io_re && (io_addr == tpcr_pkg::ADDR_CNT_LO);
    wire rd_cmp_a = io_re && (io_addr == tpcr_pkg::ADDR_CMP_A);

    wire sync_hold = prescale_control[tpcr_pkg::SYNC_HOLD_POS];
    wire psc_reset = prescale_control[tpcr_pkg::PSR_POS];
    wire [2:0] clock_sel = prescale_control[tpcr_pkg::CS_LSB +: 3];
    // width select widens counter and compare
    wire wide = width_control[tpcr_pkg::WIDTH_POS];
    wire cap_mode = width_control[tpcr_pkg::CAPEN_POS];
    wire wide_cap = wide && cap_mode;

    // ------------------------------------------------------------
    // prescaler reset and control registers
    // ------------------------------------------------------------
    // hold keeps psr; otherwise it self-clears
    wire next_psr = wr_psc ? io_wdata[tpcr_pkg::PSR_POS] : (sync_hold && psc_reset);
    wire [7:0] next_psc_ctrl = wr_psc ? (io_wdata & tpcr_pkg::PSC_CTRL_BITS) : prescale_control;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prescale_control <= tpcr_pkg::REG_RESET;
            width_control <= tpcr_pkg::REG_RESET;
            timer_irq_mask <= tpcr_pkg::REG_RESET;
        end
        else
        begin
            prescale_control <= next_psc_ctrl;
            prescale_control[tpcr_pkg::PSR_POS] <= next_psr;
            if (wr_ctrl_a)
                width_control <= io_wdata & tpcr_pkg::CTRL_A_BITS;
            if (wr_mask)
                timer_irq_mask <= io_wdata & tpcr_pkg::SRC_BITS;
        end
    end

    // ------------------------------------------------------------
    // clock source
    // ------------------------------------------------------------
    // prescaler held at zero while reset bit is set
    wire [tpcr_pkg::PSC_W-1:0] next_prescaler = psc_reset ? '0 : prescaler + 1'b1;
    // pin sampled directly, output direction does not gate it
    wire ext_fall = ext_prev && !external_count_pin;
    wire ext_rise = !ext_prev && external_count_pin;
    logic tick_sel;

    always_comb
    begin
        case (clock_sel)
            tpcr_pkg::CS_STOP: tick_sel = 1'b0;
            tpcr_pkg::CS_DIV1: tick_sel = 1'b1;
            tpcr_pkg::CS_DIV8: tick_sel = (prescaler & tpcr_pkg::TAP_DIV8) == tpcr_pkg::TAP_DIV8;
            tpcr_pkg::CS_DIV64: tick_sel = (prescaler & tpcr_pkg::TAP_DIV64) == tpcr_pkg::TAP_DIV64;
            tpcr_pkg::CS_DIV256: tick_sel = (prescaler & tpcr_pkg::TAP_DIV256) == tpcr_pkg::TAP_DIV256;
            tpcr_pkg::CS_DIV1024: tick_sel = (prescaler & tpcr_pkg::TAP_DIV1024) == tpcr_pkg::TAP_DIV1024;
            tpcr_pkg::CS_EXT_FALL: tick_sel = ext_fall;
            tpcr_pkg::CS_EXT_RISE: tick_sel = ext_rise;
            default: tick_sel = 1'b0;
        endcase
    end

    // no counting of any source while prescaler reset is held
    wire tick = tick_sel && !psc_reset;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prescaler <= '0;
            ext_prev <= 1'b0;
        end
        else
        begin
            prescaler <= next_prescaler;
            ext_prev <= external_count_pin;
        end
    end

    // ------------------------------------------------------------
    // counter and compare registers
    // ------------------------------------------------------------
    wire [7:0] next_low = count[7:0] + 8'h01;
    wire [15:0] count_inc = count + 16'h0001;
    logic [15:0] next_count;

    // low write joins latched high byte; wrap at width
    always_comb
    begin
        next_count = count;
        if (wr_cnt_lo)
            next_count = wide ? {temp_high, io_wdata} : {count[15:8], io_wdata};
        else if (wr_cnt_hi && !wide)
            // low byte keeps counting so an 8-bit tick is never lost
            next_count = {io_wdata, tick ? next_low : count[7:0]};
        else if (tick)
            next_count = wide ? count_inc : {count[15:8], next_low};
    end

    // latch takes high writes and low-byte reads
    wire [7:0] next_temp = (wide && (wr_cnt_hi || wr_cmp_b)) ? io_wdata :
                           (wide && rd_cnt_lo) ? count[15:8] :
                           (wide_cap && rd_cmp_a) ? compare_value_b : temp_high;

    wire do_capture = cap_mode && capture_event;
    // 16-bit compare load takes high byte from the latch
    wire [7:0] next_cmp_a = do_capture ? count[7:0] : (wr_cmp_a ? io_wdata : compare_value_a);
    wire [7:0] next_cmp_b = (do_capture && wide) ? count[15:8] :
                            (wr_cmp_a && wide) ? temp_high :
                            (wr_cmp_b && !wide) ? io_wdata : compare_value_b;

    // cpu low-byte write blocks matching until the next tick passes
    wire next_block = wr_cnt_lo ? 1'b1 : (tick ? 1'b0 : match_block);

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count <= '0;
            temp_high <= tpcr_pkg::REG_RESET;
            compare_value_a <= tpcr_pkg::REG_RESET;
            compare_value_b <= tpcr_pkg::REG_RESET;
            match_block <= 1'b0;
        end
        else
        begin
            count <= next_count;
            temp_high <= next_temp;
            compare_value_a <= next_cmp_a;
            compare_value_b <= next_cmp_b;
            match_block <= next_block;
        end
    end

    // ------------------------------------------------------------
    // events and flags
    // ------------------------------------------------------------
    // compare a against low byte or the 16-bit pair
    wire match_a = wide ? (count == {compare_value_b, compare_value_a}) : (count[7:0] == compare_value_a);
    wire match_b = count[7:0] == compare_value_b;
    // all ones at selected width wraps on this tick
    wire at_top = wide ? (count == tpcr_pkg::WORD_ONES) : (count[7:0] == tpcr_pkg::BYTE_ONES);
    wire set_cmp_a = tick && match_a && !match_block && !cap_mode;
    wire set_cmp_b = tick && match_b && !match_block && !wide;
    wire set_ovf = tick && at_top;
    wire set_cap = do_capture;

    logic [7:0] set_vec;
    logic [7:0] ack_vec;

    always_comb
    begin
        set_vec = '0;
        ack_vec = '0;
        set_vec[tpcr_pkg::CMPA_POS] = set_cmp_a;
        set_vec[tpcr_pkg::CMPB_POS] = set_cmp_b;
        set_vec[tpcr_pkg::OVF_POS] = set_ovf;
        set_vec[tpcr_pkg::CAP_POS] = set_cap;
        for (int i = 0; i < tpcr_pkg::NUM_SRC; i++)
            ack_vec[tpcr_pkg::SRC_POS[i]] = irq_ack[i];
    end

    // write-one or vector clears; a same-cycle event wins
    wire [7:0] clr_vec = (wr_flags ? io_wdata : 8'h00) | ack_vec;
    wire [7:0] next_flags = ((timer_irq_flags & ~clr_vec) | set_vec) & tpcr_pkg::SRC_BITS;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            timer_irq_flags <= tpcr_pkg::REG_RESET;
        else
            timer_irq_flags <= next_flags;
    end

    // request only when enable, global enable and flag agree
    generate
        for (genvar g = 0; g < tpcr_pkg::NUM_SRC; g++)
        begin : g_req
            always_ff @(posedge mclk or posedge sys_rst)
            begin
                if (sys_rst)
                    irq_req[g] <= 1'b0;
                else
                    irq_req[g] <= global_irq_enable && timer_irq_mask[tpcr_pkg::SRC_POS[g]]
                                  && next_flags[tpcr_pkg::SRC_POS[g]];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] read_mux;

    // compare b reads direct unless it is the capture high byte
    always_comb
    begin
        case (io_addr)
            tpcr_pkg::ADDR_CNT_LO: read_mux = count[7:0];
            tpcr_pkg::ADDR_CNT_HI: read_mux = wide ? temp_high : count[15:8];
            tpcr_pkg::ADDR_CMP_A: read_mux = compare_value_a;
            tpcr_pkg::ADDR_CMP_B: read_mux = wide_cap ? temp_high : compare_value_b;
            tpcr_pkg::ADDR_CTRL_A: read_mux = width_control;
            tpcr_pkg::ADDR_PSC_CTRL: read_mux = prescale_control;
            tpcr_pkg::ADDR_FLAGS: read_mux = timer_irq_flags;
            tpcr_pkg::ADDR_MASK: read_mux = timer_irq_mask;
            default: read_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            io_rdata <= 8'h00;
        else if (io_re)
            io_rdata <= read_mux;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    psr_hold_a: assert property (sync_hold && psc_reset && !wr_psc |=> psc_reset)
        else $error("prescaler reset dropped while sync hold set");
    psr_release_a: assert property (wr_psc && !io_wdata[tpcr_pkg::SYNC_HOLD_POS] ##1 !wr_psc |=> !psc_reset)
        else $error("prescaler reset not cleared after hold release");
    psr_pulse_a: assert property (psc_reset |-> !tick ##0 (psc_reset && !sync_hold && !wr_psc) [*1] |=> !psc_reset)
        else $error("prescaler reset did not self clear");
    div8_gap_a: assert property (tick && clock_sel == tpcr_pkg::CS_DIV8 |=> (!tick || clock_sel != tpcr_pkg::CS_DIV8) [*7])
        else $error("divide by 8 ticked too early");
    ext_rise_a: assert property (clock_sel == tpcr_pkg::CS_EXT_RISE && !psc_reset && ext_rise && !wr_cnt_lo
                                 |=> count[7:0] == $past(next_low))
        else $error("rising pin edge not counted");
    write_block_a: assert property (wr_cnt_lo ##1 tick |-> !set_cmp_a && !set_cmp_b)
        else $error("compare matched right after counter write");
    wide_load_a: assert property (wide && wr_cnt_lo |=> count == {$past(temp_high), $past(io_wdata)})
        else $error("16-bit counter load wrong");
    capture_no_a_a: assert property (cap_mode |-> !set_cmp_a)
        else $error("compare a flag set in capture mode");
    wide_no_b_a: assert property (wide |=> !timer_irq_flags[tpcr_pkg::CMPB_POS] || $past(timer_irq_flags[tpcr_pkg::CMPB_POS]))
        else $error("compare b flag set in 16-bit mode");
    flag_clear_a: assert property (wr_flags && io_wdata[tpcr_pkg::OVF_POS] && !set_ovf
                                   |=> !timer_irq_flags[tpcr_pkg::OVF_POS])
        else $error("overflow flag not cleared by write one");
    wrap8_a: assert property (tick && !wide && count[7:0] == tpcr_pkg::BYTE_ONES && !wr_cnt_lo
                              |=> count[7:0] == 8'h00 && timer_irq_flags[tpcr_pkg::OVF_POS])
        else $error("8-bit wrap or overflow flag missing");
    irq_gate_a: assert property (irq_req[3] |-> $past(global_irq_enable) && $past(timer_irq_mask[tpcr_pkg::CMPA_POS])
                                 && timer_irq_flags[tpcr_pkg::CMPA_POS])
        else $error("compare a request without enable or flag");
    wrap16_a: assert property (tick && wide && count == tpcr_pkg::WORD_ONES && !wr_cnt_lo
                               |=> count == '0 && timer_irq_flags[tpcr_pkg::OVF_POS])
        else $error("16-bit wrap or overflow flag missing");
    cmp_read_a: assert property (io_re && io_addr == tpcr_pkg::ADDR_CMP_B && wide && !cap_mode
                                 |=> io_rdata == $past(compare_value_b))
        else $error("16-bit compare high byte not read directly");

    wide_match_c: cover property (wide && set_cmp_a);
    ext_fall_c: cover property (clock_sel == tpcr_pkg::CS_EXT_FALL && tick);
    wide_wrap_c: cover property (wide && set_ovf);
    blocked_match_c: cover property (match_block && tick && match_a);

endmodule // tpcr_timer

/* File: hw/tpcr_pkg.sv */
// constants for the 8/16-bit timer/counter register block
// assumes an 8-bit cpu i/o bus with a 6-bit i/o address
package tpcr_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_CNT_HI = 6'h14;
    localparam logic [5:0] ADDR_CTRL_A = 6'h15;
    localparam logic [5:0] ADDR_PSC_CTRL = 6'h33;
    localparam logic [5:0] ADDR_FLAGS = 6'h38;
    localparam logic [5:0] ADDR_MASK = 6'h39;
    localparam logic [5:0] ADDR_CNT_LO = 6'h12;
    localparam logic [5:0] ADDR_CMP_A = 6'h13;
    localparam logic [5:0] ADDR_CMP_B = 6'h16;

    // ------------------------------------------------------------
    // field positions and writable masks
    // ------------------------------------------------------------
    localparam int SYNC_HOLD_POS = 4;
    localparam int PSR_POS = 3;
    localparam int CS_LSB = 0;
    localparam int WIDTH_POS = 7;
    localparam int CAPEN_POS = 6;
    localparam int CMPA_POS = 4;
    localparam int CMPB_POS = 3;
    localparam int OVF_POS = 1;
    localparam int CAP_POS = 0;
    localparam int NUM_SRC = 4;
    // irq_req/irq_ack index order: cap, ovf, cmp b, cmp a
    localparam int SRC_POS [NUM_SRC] = '{CAP_POS, OVF_POS, CMPB_POS, CMPA_POS};
    localparam logic [7:0] PSC_CTRL_BITS = 8'h1f;
    localparam logic [7:0] CTRL_A_BITS = 8'hc0;
    localparam logic [7:0] SRC_BITS = 8'h1b;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hff;
    localparam logic [15:0] WORD_ONES = 16'hffff;

    // ------------------------------------------------------------
    // clock select codes and prescaler taps
    // ------------------------------------------------------------
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam int PSC_W = 10;
    localparam logic [PSC_W-1:0] TAP_DIV8 = 10'h007;
    localparam logic [PSC_W-1:0] TAP_DIV64 = 10'h03f;
    localparam logic [PSC_W-1:0] TAP_DIV256 = 10'h0ff;
    localparam logic [PSC_W-1:0] TAP_DIV1024 = 10'h3ff;

endpackage

/* File: testbench/tpcr_cpu_model.sv */
// interrupt side of the cpu core facing the timer block
// assumes irq_req is a registered level and irq_ack is sampled on mclk
`timescale 1ns/1ns

module tpcr_cpu_model
(
    input wire logic mclk, // system clock
    input wire logic sys_rst, // async reset, active high
    input wire logic vec_en, // vector dispatch allowed
    input wire logic [3:0] irq_req, // requests from the timer
    output logic [3:0] irq_ack // vector executed, one cycle
);
    logic [1:0] wait_cnt;
    logic [3:0] next_ack;

    // ----------------------------------------
    // dispatch
    // ----------------------------------------
    // vector only a live request, lowest first
    assign next_ack = irq_req & (~irq_req + 4'h1);

    // latency of a few cycles, like a cpu finishing its instruction
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_ack <= 4'h0;
            wait_cnt <= 2'h0;
        end
        else if (irq_ack != 4'h0 || !vec_en || irq_req == 4'h0)
        begin
            irq_ack <= 4'h0;
            wait_cnt <= 2'h0;
        end
        else if (wait_cnt == 2'h2)
        begin
            irq_ack <= next_ack;
            wait_cnt <= 2'h0;
        end
        else
            wait_cnt <= wait_cnt + 2'h1;
    end
endmodule // tpcr_cpu_model

/* File: testbench/tb.sv */
// self-checking bench for the timer register block
// assumes the one-cycle strobe bus of the block, driven on falling edges
`timescale 1ns/1ns

module tb;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00;
    logic io_we = 1'b0;
    logic io_re = 1'b0;
    logic [7:0] io_rdata;
    logic ext_pin = 1'b0;
    logic gie = 1'b0;
    logic cap_ev = 1'b0;
    logic vec_en = 1'b0;
    logic [3:0] irq_ack;
    logic [3:0] irq_req;
    int errors = 0;
    int tests_run = 0;
    int i;
    logic [7:0] rd;
    logic [7:0] a0;
    logic [5:0] regs [8] = '{6'h14, 6'h33, 6'h38, 6'h39, 6'h12, 6'h13, 6'h16, 6'h00};
    int win [6] = '{20, 20, 64, 640, 2560, 10240};
    logic [7:0] tck [6] = '{8'h00, 8'h14, 8'h08, 8'h0a, 8'h0a, 8'h0a};

    always #50 mclk = ~mclk;

    tpcr_timer tpcr_timer_i (.mclk(mclk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata), .external_count_pin(ext_pin),
        .global_irq_enable(gie), .capture_event(cap_ev), .irq_ack(irq_ack), .irq_req(irq_req));
    tpcr_cpu_model tpcr_cpu_model_i (.mclk(mclk), .sys_rst(sys_rst), .vec_en(vec_en),
        .irq_req(irq_req), .irq_ack(irq_ack));

    // ----------------------------------------
    // bus tasks, each starts and ends on a falling edge
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // idle cycle after each access keeps strobes from being set twice at once
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_we = 1'b1;
        @(negedge mclk);
        io_we = 1'b0;
        @(negedge mclk);
    endtask

    task automatic rdb(input logic [5:0] a);
        io_addr = a;
        io_re = 1'b1;
        @(negedge mclk);
        io_re = 1'b0;
        rd = io_rdata;
        @(negedge mclk);
    endtask

    task automatic rc(input logic [5:0] a, input logic [7:0] e, input string nm);
        rdb(a);
        chk(nm, rd, e);
    endtask

    task automatic run(input int n);
        wr(6'h33, 8'h01);
        repeat (n) @(negedge mclk);
        wr(6'h33, 8'h00);
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        for (i = 0; i < 8; i++)
            rc(regs[i], 8'h00, "reset");
        wr(6'h39, 8'hff);
        rc(6'h39, 8'h1b, "mask");
        wr(6'h39, 8'h00);
        wr(6'h33, 8'he0);
        rc(6'h33, 8'h00, "psc_hi");
        wr(6'h33, 8'h09);
        rc(6'h33, 8'h01, "psr_self");
        wr(6'h33, 8'h19);
        rc(6'h33, 8'h19, "psr_hold");
        rdb(6'h12);
        a0 = rd;
        repeat (20) @(negedge mclk);
        rc(6'h12, a0, "halted");
        wr(6'h33, 8'h09);
        rc(6'h33, 8'h01, "psr_drop");
        // windows are whole divider periods, so the tick count is exact
        for (i = 0; i < 6; i++)
        begin
            wr(6'h33, {5'h00, i[2:0]});
            rdb(6'h12);
            a0 = rd;
            repeat (win[i] - 2) @(negedge mclk);
            rdb(6'h12);
            chk("ticks", rd - a0, tck[i]);
        end
        for (i = 6; i < 8; i++)
        begin
            wr(6'h33, {5'h00, i[2:0]});
            rdb(6'h12);
            a0 = rd;
            // bench toggles the pin as firmware would
            repeat (3)
            begin
                ext_pin = 1'b1;
                repeat (3) @(negedge mclk);
                ext_pin = 1'b0;
                repeat (3) @(negedge mclk);
            end
            rdb(6'h12);
            chk("edges", rd - a0, 8'h03);
        end
        wr(6'h33, 8'h00);
        wr(6'h13, 8'h10);
        wr(6'h16, 8'h12);
        wr(6'h12, 8'h0e);
        wr(6'h38, 8'hff);
        run(10);
        rc(6'h38, 8'h18, "cmp8");
        wr(6'h38, 8'h08);
        rc(6'h38, 8'h10, "w1c");
        wr(6'h38, 8'h10);
        wr(6'h16, 8'h40);
        wr(6'h12, 8'h10);
        run(0);
        rc(6'h38, 8'h00, "blocked");
        wr(6'h12, 8'hfd);
        run(6);
        rc(6'h38, 8'h02, "ovf8");
        wr(6'h38, 8'hff);
        wr(6'h15, 8'h40);
        wr(6'h12, 8'h0e);
        run(10);
        cap_ev = 1'b1;
        @(negedge mclk);
        cap_ev = 1'b0;
        rc(6'h38, 8'h01, "capmode");
        wr(6'h15, 8'h80);
        wr(6'h16, 8'h01); // high byte before low
        wr(6'h13, 8'h05);
        wr(6'h14, 8'h01);
        wr(6'h12, 8'hff);
        wr(6'h14, 8'h77);
        rc(6'h14, 8'h77, "latch");
        rc(6'h12, 8'hff, "cnt_lo");
        rc(6'h14, 8'h01, "cnt_hi");
        wr(6'h14, 8'h77);
        rc(6'h16, 8'h01, "cmp_hi");
        rc(6'h13, 8'h05, "cmp_lo");
        wr(6'h14, 8'h01);
        wr(6'h12, 8'h00);
        wr(6'h38, 8'hff);
        wr(6'h39, 8'h1b);
        gie = 1'b1;
        run(10);
        rc(6'h38, 8'h10, "cmp16");
        chk("req", {4'h0, irq_req}, 8'h08);
        gie = 1'b0;
        @(negedge mclk);
        chk("req_off", {4'h0, irq_req}, 8'h00);
        gie = 1'b1;
        vec_en = 1'b1;
        @(negedge mclk);
        for (i = 0; i < 20 && irq_req !== 4'h0; i++)
            @(negedge mclk);
        if (i == 20)
            errors++;
        else
        begin
            vec_en = 1'b0;
            gie = 1'b0;
            rc(6'h38, 8'h00, "vec_clr");
            wr(6'h14, 8'hff);
            wr(6'h12, 8'hfd);
            run(6);
            rc(6'h38, 8'h02, "ovf16");
        end
        close_out();
    end
endmodule // tb
